// *** pkg/vif_pkg.sv ***
// constants and types shared by the vlan ingress filter and its buffer
package vif_pkg;
    // port count and field widths
    localparam int          PORTS      = 4;
    localparam int          VID_W      = 12;
    localparam int          TBL_DEPTH  = 4096;
    localparam int          ADDR_W     = 8;
    localparam int          ENTRY_W    = 5;
    localparam logic [11:0] VID_LAST   = 12'hfff;

    // register byte addresses
    localparam logic [7:0]  REG_PORT_CFG = 8'h00;
    localparam logic [7:0]  REG_TBL_ADDR = 8'h04;
    localparam logic [7:0]  REG_TBL_DATA = 8'h08;
    localparam logic [7:0]  REG_COUNTS   = 8'h0c;
    localparam logic [7:0]  REG_PORT_ADD = 8'h10;
    localparam logic [7:0]  REG_PORT_DEL = 8'h14;
    localparam logic [7:0]  REG_STATE    = 8'h18;

    // per-port config nibble: bit0 filter, bit1 default vid select, bits3:2 egress mode
    localparam int          CFG_FILT     = 0;
    localparam int          CFG_DSEL     = 1;
    localparam int          CFG_MODE     = 2;
    localparam logic [15:0] PORT_CFG_RST = 16'h0000;

    // table entry layout: bit4 defined, bits3:0 member ports
    localparam int          ENT_DEF      = 4;
    localparam int          OP_PORT_LSB  = 16;

    // default vid values selectable per port
    localparam logic [11:0] DEF_VID_A    = 12'h001;
    localparam logic [11:0] DEF_VID_B    = 12'h002;

    // egress modes
    localparam logic [1:0]  MODE_PASS    = 2'h0;
    localparam logic [1:0]  MODE_STRIP   = 2'h1;
    localparam logic [1:0]  MODE_INSERT  = 2'h2;

    // egress actions per port
    localparam logic [1:0]  ACT_KEEP     = 2'h0;
    localparam logic [1:0]  ACT_STRIP    = 2'h1;
    localparam logic [1:0]  ACT_INSERT   = 2'h2;

    // inserted tag: tpid, zero priority and dei
    localparam logic [15:0] TAG_TPID     = 16'h8100;
    localparam logic [3:0]  TAG_PRI_DEI  = 4'h0;

    // descriptor buffer
    localparam int          DESC_W       = 30;
    localparam logic [1:0]  BUF_DEPTH    = 2'h2;

    typedef enum logic {
        VIF_ST_INIT,
        VIF_ST_RUN
    } vif_state_t;
endpackage : vif_pkg

// *** hdl/vif_buf.sv ***
// two-entry descriptor buffer, output taken from the head entry flop
`timescale 1ns/1ps
module vif_buf #(
    parameter int W = 30
) (
    input  wire logic         sys_clk,  // system clock
    input  wire logic         rst,      // async reset, high
    input  wire logic         en,       // allow filling next cycle
    input  wire logic         in_valid, // write request
    output logic              in_ready, // space free, registered
    input  wire logic [W-1:0] in_data,  // write word
    output logic              out_valid,// head valid, registered
    input  wire logic         out_ready,// drain side accepts
    output logic [W-1:0]      out_data  // head word
);
    logic [1:0]   cnt;
    logic [1:0]   next_cnt;
    logic [W-1:0] e0;
    logic [W-1:0] e1;
    logic [W-1:0] next_e0;
    logic [W-1:0] next_e1;
    logic         next_in_ready;
    logic         next_out_valid;
    logic         push;
    logic         pop;
    logic [1:0]   slot;

    // shift on pop then write at the first free slot
    always_comb begin
        push     = in_valid & in_ready;
        pop      = out_valid & out_ready;
        next_e0  = e0;
        next_e1  = e1;
        next_cnt = cnt;
        if (pop) begin
            next_e0  = e1;
            next_cnt = cnt - 2'h1;
        end
        slot = next_cnt;
        if (push) begin
            if (slot == 2'h0) begin
                next_e0 = in_data;
            end else begin
                next_e1 = in_data;
            end
            next_cnt = next_cnt + 2'h1;
        end
        // flags registered so the ports come straight from flops
        next_in_ready  = en && (next_cnt != vif_pkg::BUF_DEPTH);
        next_out_valid = (next_cnt != 2'h0);
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cnt       <= 2'h0;
            e0        <= '0;
            e1        <= '0;
            in_ready  <= 1'b0;
            out_valid <= 1'b0;
        end else begin
            cnt       <= next_cnt;
            e0        <= next_e0;
            e1        <= next_e1;
            in_ready  <= next_in_ready;
            out_valid <= next_out_valid;
        end
    end

    assign out_data = e0;
endmodule : vif_buf

// *** hdl/vif_filter.sv ***
// vlan classification, ingress filtering and egress tag decision for a four-port switch
//
// The register offsets and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
// Behaviour
// R01 - table keeps a four-port member set per vid; ports added or removed singly
// R02 - each port selects default vid 1 or 2; reset gives 1
// R03 - per-port filter enable bit written by software
// R04 - untagged frames take port default vid and stay within that vlan
// R05 - tagged frame from member port goes only to that vlan's members
// R06 - filter off: known vid, non-member source, still forwarded to members
// R07 - filter on: known vid, non-member source, dropped at ingress only
// R08 - filter off: unknown vid forwarded by address mask, vlans ignored
// R09 - filter on: unknown vid dropped at ingress and on exit
// R10 - passthrough port sends vlan frames with tag state unchanged
// R11 - strip port removes tag from every vlan member frame
// R12 - insert port adds tag to every vlan member frame
// R13 - inserted tag is 802.1q with classified vid; fcs redone on change
module vif_filter (
    input  wire logic        sys_clk,      // 125 MHz clock
    input  wire logic        rst,          // async reset, high
    input  wire logic [7:0]  reg_addr,     // register byte address
    input  wire logic [31:0] reg_wdata,    // register write data
    input  wire logic        reg_wr,       // write strobe
    input  wire logic        reg_rd,       // read strobe
    output logic      [31:0] reg_rdata,    // read data, cycle after strobe
    input  wire logic        in_valid,     // ingress descriptor valid
    output logic             in_ready,     // descriptor accepted
    input  wire logic [1:0]  in_port,      // receiving port
    input  wire logic        in_tagged,    // frame carried a tag
    input  wire logic [11:0] in_vid,       // received vid
    input  wire logic [3:0]  in_fwd_mask,  // address lookup port mask
    output logic             out_valid,    // decision valid
    input  wire logic        out_ready,    // decision consumed
    output logic             out_drop,     // frame is discarded
    output logic      [3:0]  out_mask,     // egress ports
    output logic      [11:0] out_vid,      // classified vid
    output logic             out_tagged,   // frame arrived tagged
    output logic      [7:0]  out_tag_act,  // two bits per egress port
    output logic      [3:0]  out_fcs_redo, // fcs must be recomputed per port
    output logic      [31:0] out_tag_word  // tag to insert
);
    vif_pkg::vif_state_t state;
    vif_pkg::vif_state_t next_state;
    logic [11:0] init_idx;
    logic [11:0] next_init_idx;

    logic [15:0] port_cfg;
    logic [15:0] next_port_cfg;
    logic [11:0] tbl_addr;
    logic [11:0] next_tbl_addr;
    logic [15:0] fwd_cnt;
    logic [15:0] next_fwd_cnt;
    logic [15:0] drop_cnt;
    logic [15:0] next_drop_cnt;
    logic [31:0] next_rdata;

    // membership table, not reset; swept to empty after reset instead
    logic [4:0]  vlan_tbl [vif_pkg::TBL_DEPTH];
    logic        tbl_we;
    logic [11:0] tbl_wa;
    logic [4:0]  tbl_wd;
    logic [11:0] op_vid;
    logic [3:0]  op_bit;
    logic [4:0]  op_old;

    logic [11:0] sel_vid;
    logic [4:0]  entry;
    logic        defined;
    logic        member;
    logic        filt;
    logic [3:0]  filt_all;
    logic [3:0]  mask;
    logic        drop;
    logic [7:0]  act;
    logic [3:0]  redo;
    logic        push;
    logic        buf_in_ready;
    logic [vif_pkg::DESC_W-1:0] desc_in;
    logic [vif_pkg::DESC_W-1:0] desc_out;

    // sweep every table entry to undefined before taking frames
    always_comb begin
        next_state    = state;
        next_init_idx = init_idx;
        unique case (state)
            vif_pkg::VIF_ST_INIT: begin
                next_init_idx = init_idx + 12'h001;
                if (init_idx == vif_pkg::VID_LAST) begin
                    next_state = vif_pkg::VIF_ST_RUN;
                end
            end
            vif_pkg::VIF_ST_RUN: begin
                next_init_idx = init_idx;
            end
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state    <= vif_pkg::VIF_ST_INIT;
            init_idx <= 12'h000;
        end else begin
            state    <= next_state;
            init_idx <= next_init_idx;
        end
    end

    // table write port: sweep, whole-entry write, or single port add/remove
    always_comb begin
        op_vid = reg_wdata[11:0];
        op_bit = 4'h1 << reg_wdata[vif_pkg::OP_PORT_LSB +: 2];
        op_old = vlan_tbl[op_vid];
        tbl_we = 1'b0;
        tbl_wa = tbl_addr;
        tbl_wd = reg_wdata[4:0];
        if (state == vif_pkg::VIF_ST_INIT) begin
            tbl_we = 1'b1;
            tbl_wa = init_idx;
            tbl_wd = 5'h00;
        end else if (reg_wr && reg_addr == vif_pkg::REG_TBL_DATA) begin
            tbl_we = 1'b1;                                              // R01
        end else if (reg_wr && reg_addr == vif_pkg::REG_PORT_ADD) begin
            tbl_we = 1'b1;
            tbl_wa = op_vid;
            tbl_wd = op_old | {1'b1, op_bit};                           // R01
        end else if (reg_wr && reg_addr == vif_pkg::REG_PORT_DEL) begin
            tbl_we = 1'b1;
            tbl_wa = op_vid;
            tbl_wd = op_old & ~{1'b0, op_bit};                          // R01
        end
    end

    always_ff @(posedge sys_clk) begin
        if (tbl_we) begin
            vlan_tbl[tbl_wa] <= tbl_wd;
        end
    end

    // classification: untagged frames use the port default vid
    always_comb begin
        filt = port_cfg[{in_port, 2'b00} + vif_pkg::CFG_FILT];          // R03
        if (in_tagged) begin
            sel_vid = in_vid;
        end else if (port_cfg[{in_port, 2'b00} + vif_pkg::CFG_DSEL]) begin
            sel_vid = vif_pkg::DEF_VID_B;                               // R02
        end else begin
            sel_vid = vif_pkg::DEF_VID_A;                               // R02
        end
        entry   = vlan_tbl[sel_vid];
        defined = entry[vif_pkg::ENT_DEF];
        member  = entry[in_port];
    end

    // filter action table
    always_comb begin
        if (!in_tagged) begin
            mask = in_fwd_mask & entry[3:0];                            // R04
        end else if (defined && member) begin
            mask = in_fwd_mask & entry[3:0];                            // R05
        end else if (defined) begin
            mask = filt ? 4'h0 : (in_fwd_mask & entry[3:0]);            // R06 R07
        end else begin
            // unknown vid: filtered ports refuse it on exit as well
            mask = filt ? 4'h0 : (in_fwd_mask & ~filt_all);             // R08 R09
        end
        drop = (mask == 4'h0);
    end

    // per-port egress tag decision
    genvar p;
    generate
        for (p = 0; p < vif_pkg::PORTS; p++) begin : g_port
            logic [1:0] mode;
            assign mode        = port_cfg[4*p + vif_pkg::CFG_MODE +: 2];
            assign filt_all[p] = port_cfg[4*p + vif_pkg::CFG_FILT];
            // frames outside a defined vlan always leave unchanged
            assign act[2*p +: 2] =
                (!mask[p] || !defined)                   ? vif_pkg::ACT_KEEP :
                (mode == vif_pkg::MODE_STRIP && in_tagged)   ? vif_pkg::ACT_STRIP :  // R11
                (mode == vif_pkg::MODE_INSERT && !in_tagged) ? vif_pkg::ACT_INSERT : // R12
                vif_pkg::ACT_KEEP;                                      // R10
            assign redo[p] = (act[2*p +: 2] != vif_pkg::ACT_KEEP);      // R13
        end
    endgenerate

    assign push    = in_valid & buf_in_ready;
    assign desc_in = {drop, mask, sel_vid, in_tagged, act, redo};

    // two entries so a stalled receiver loses no decision
    vif_buf #(
        .W (vif_pkg::DESC_W)
    ) u_buf (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .en        (next_state == vif_pkg::VIF_ST_RUN),
        .in_valid  (in_valid),
        .in_ready  (buf_in_ready),
        .in_data   (desc_in),
        .out_valid (out_valid),
        .out_ready (out_ready),
        .out_data  (desc_out)
    );

    assign in_ready     = buf_in_ready;
    assign out_drop     = desc_out[29];
    assign out_mask     = desc_out[28:25];
    assign out_vid      = desc_out[24:13];
    assign out_tagged   = desc_out[12];
    assign out_tag_act  = desc_out[11:4];
    assign out_fcs_redo = desc_out[3:0];
    assign out_tag_word = {vif_pkg::TAG_TPID, vif_pkg::TAG_PRI_DEI, out_vid}; // R13

    // register writes, frame counters and read mux
    always_comb begin
        next_port_cfg = port_cfg;
        next_tbl_addr = tbl_addr;
        next_fwd_cnt  = fwd_cnt;
        next_drop_cnt = drop_cnt;
        next_rdata    = 32'h0000_0000;
        if (reg_wr && reg_addr == vif_pkg::REG_PORT_CFG) begin
            next_port_cfg = reg_wdata[15:0];                            // R02 R03
        end
        if (reg_wr && reg_addr == vif_pkg::REG_TBL_ADDR) begin
            next_tbl_addr = reg_wdata[11:0];
        end
        // counters wrap; software samples differences
        if (push && drop) begin
            next_drop_cnt = drop_cnt + 16'h0001;
        end else if (push) begin
            next_fwd_cnt = fwd_cnt + 16'h0001;
        end
        if (reg_rd) begin
            unique case (reg_addr)
                vif_pkg::REG_PORT_CFG: next_rdata = {16'h0000, port_cfg};
                vif_pkg::REG_TBL_ADDR: next_rdata = {20'h00000, tbl_addr};
                vif_pkg::REG_TBL_DATA: next_rdata = {27'h0000000, vlan_tbl[tbl_addr]};
                vif_pkg::REG_COUNTS:   next_rdata = {drop_cnt, fwd_cnt};
                vif_pkg::REG_STATE:    next_rdata = {31'h00000000, (state == vif_pkg::VIF_ST_RUN)};
                default:               next_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            port_cfg  <= vif_pkg::PORT_CFG_RST;
            tbl_addr  <= 12'h000;
            fwd_cnt   <= 16'h0000;
            drop_cnt  <= 16'h0000;
            reg_rdata <= 32'h0000_0000;
        end else begin
            port_cfg  <= next_port_cfg;
            tbl_addr  <= next_tbl_addr;
            fwd_cnt   <= next_fwd_cnt;
            drop_cnt  <= next_drop_cnt;
            reg_rdata <= next_rdata;
        end
    end
endmodule : vif_filter

// *** testbench/vif_filter_assertions.sv ***
// concurrent checks on the vlan filter ports
`timescale 1ns/1ps
module vif_filter_assertions (
    input wire logic        sys_clk,      // clock
    input wire logic        rst,          // async reset
    input wire logic        reg_rd,       // read strobe
    input wire logic [31:0] reg_rdata,    // read data
    input wire logic        in_valid,     // ingress valid
    input wire logic        in_ready,     // ingress ready
    input wire logic        out_valid,    // decision valid
    input wire logic        out_ready,    // decision taken
    input wire logic        out_drop,     // discard
    input wire logic [3:0]  out_mask,     // egress ports
    input wire logic [11:0] out_vid,      // classified vid
    input wire logic        out_tagged,   // arrived tagged
    input wire logic [7:0]  out_tag_act,  // per port action
    input wire logic [3:0]  out_fcs_redo, // per port fcs redo
    input wire logic [31:0] out_tag_word  // tag to insert
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic [3:0]  is_act;
    logic [3:0]  is_strip;
    logic [3:0]  is_ins;
    // per port decode of the two-bit actions
    always_comb begin
        for (int p = 0; p < 4; p++) begin
            is_act[p]   = out_tag_act[2*p +: 2] != 2'h0;
            is_strip[p] = out_tag_act[2*p +: 2] == 2'h1;
            is_ins[p]   = out_tag_act[2*p +: 2] == 2'h2;
        end
    end
    sequence s_take;
        in_valid && in_ready && !out_valid;
    endsequence
    sequence s_stall;
        out_valid && !out_ready;
    endsequence
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data not zero outside its cycle");
    a_drop_empty: assert property (out_valid |-> out_drop == (out_mask == 4'h0))
        else $error("drop flag disagrees with mask");
    a_tag_format: assert property (out_valid |-> out_tag_word == {16'h8100, 4'h0, out_vid})
        else $error("inserted tag word malformed");
    a_fcs_follow: assert property (out_valid |-> out_fcs_redo == is_act)
        else $error("fcs redo does not follow tag action");
    a_act_masked: assert property (out_valid |-> (is_act & ~out_mask) == 4'h0)
        else $error("tag action on a port outside the mask");
    a_stall_hold: assert property (s_stall |=> out_valid && $stable({out_drop, out_mask, out_vid, out_tag_act}))
        else $error("decision moved while stalled");
    a_take_latency: assert property (s_take |=> out_valid)
        else $error("decision not out one cycle after take");
    a_strip_tagged: assert property (out_valid && (is_strip != 4'h0) |-> out_tagged)
        else $error("strip on an untagged frame");
    a_insert_untag: assert property (out_valid && (is_ins != 4'h0) |-> !out_tagged)
        else $error("insert on a tagged frame");
    a_default_vid: assert property (out_valid && !out_tagged |-> out_vid inside {12'h001, 12'h002})
        else $error("untagged frame not on a default vid");
endmodule : vif_filter_assertions

bind vif_filter vif_filter_assertions vif_filter_assertions_i (
    .sys_clk(sys_clk), .rst(rst), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .in_valid(in_valid), .in_ready(in_ready), .out_valid(out_valid), .out_ready(out_ready),
    .out_drop(out_drop), .out_mask(out_mask), .out_vid(out_vid), .out_tagged(out_tagged),
    .out_tag_act(out_tag_act), .out_fcs_redo(out_fcs_redo), .out_tag_word(out_tag_word)
);

// *** testbench/vif_sink.sv ***
// decision consumer model that stalls on command
`timescale 1ns/1ps
module vif_sink (
    input  wire logic        sys_clk,   // clock
    input  wire logic        rst,       // async reset
    input  wire logic        stall,     // hold off acceptance
    input  wire logic        out_valid, // decision valid
    output logic             out_ready, // accept
    input  wire logic [28:0] word,      // decision fields
    output logic             got,       // one taken last edge
    output logic      [28:0] got_word   // what was taken
);
    // ready is combinational so a stall bites at once
    assign out_ready = !stall;
    // record every accepted decision
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            got      <= 1'b0;
            got_word <= 29'h0;
        end else begin
            got      <= out_valid && out_ready;
            got_word <= word;
        end
    end
endmodule : vif_sink

// *** testbench/vif_filter_tb.sv ***
// self-checking bench for the vlan ingress filter
`timescale 1ns/1ps
module vif_filter_tb;
    logic        sys_clk;
    logic        rst = 1'b1;
    logic [7:0]  reg_addr = 8'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic        in_valid = 1'b0;
    logic        in_ready;
    logic [1:0]  in_port = 2'h0;
    logic        in_tagged = 1'b0;
    logic [11:0] in_vid = 12'h0;
    logic [3:0]  in_fwd_mask = 4'h0;
    logic        out_valid, out_ready, out_drop, out_tagged, stall = 1'b0, got;
    logic [3:0]  out_mask, out_fcs_redo;
    logic [11:0] out_vid;
    logic [7:0]  out_tag_act;
    logic [31:0] out_tag_word;
    logic [28:0] got_word;
    logic [31:0] q[$];
    int          n_fail = 0, n_tests = 0, cyc = 0, k;

    vif_filter vif_filter_i (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .in_valid(in_valid), .in_ready(in_ready),
        .in_port(in_port), .in_tagged(in_tagged), .in_vid(in_vid), .in_fwd_mask(in_fwd_mask),
        .out_valid(out_valid), .out_ready(out_ready), .out_drop(out_drop), .out_mask(out_mask),
        .out_vid(out_vid), .out_tagged(out_tagged), .out_tag_act(out_tag_act),
        .out_fcs_redo(out_fcs_redo), .out_tag_word(out_tag_word));
    vif_sink vif_sink_i (.sys_clk(sys_clk), .rst(rst), .stall(stall), .out_valid(out_valid),
        .out_ready(out_ready), .word({out_drop, out_mask, out_vid, out_tag_act, out_fcs_redo}),
        .got(got), .got_word(got_word));

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    // collect decisions; a cycle ceiling cuts a hang short
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (got) q.push_back({3'h0, got_word});
        if (cyc == 20000) begin
            n_fail++;
            results();
        end
    end

    task automatic results;
        if (n_fail == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : results
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] seen);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
    endtask : wr
    // read data is looked at mid-cycle after the strobe, its only cycle
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        @(negedge sys_clk);
        chk(nm, exp, reg_rdata);
    endtask : rd
    // ready is sampled at the falling edge so the taking edge is known
    task automatic push(input logic [1:0] p, input logic t, input logic [11:0] v, input logic [3:0] f);
        @(posedge sys_clk);
        in_port     <= p;
        in_tagged   <= t;
        in_vid      <= v;
        in_fwd_mask <= f;
        in_valid    <= 1'b1;
        @(negedge sys_clk);
        for (k = 0; k < 50 && in_ready !== 1'b1; k++) @(negedge sys_clk);
        if (k == 50) n_fail++;
        @(posedge sys_clk);
        in_valid <= 1'b0;
    endtask : push
    task automatic pop(input logic d, input logic [3:0] m, input logic [11:0] v, input logic [7:0] a);
        logic [3:0] fc;
        for (int p = 0; p < 4; p++) fc[p] = a[2*p +: 2] != 2'h0;
        for (k = 0; k < 50 && q.size() == 0; k++) @(negedge sys_clk);
        if (q.size() == 0) chk("decision missing", 32'h1, 32'h0);
        else chk("decision", {3'h0, d, m, v, a, fc}, q.pop_front());
    endtask : pop

    // main sequence
    initial begin
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        rd(vif_pkg::REG_PORT_CFG, 32'h0, "cfg reset");
        rd(8'h1c, 32'h0, "unmapped");
        for (k = 0; k < 6000 && in_ready !== 1'b1; k++) @(negedge sys_clk);
        rd(vif_pkg::REG_STATE, 32'h1, "sweep done");
        // p0 open strip, p1 filtered insert, p2 open passthrough, p3 filtered vid 2
        wr(vif_pkg::REG_PORT_CFG, 32'h3094);
        rd(vif_pkg::REG_PORT_CFG, 32'h3094, "cfg");
        for (int p = 0; p < 3; p++) begin
            // port index sits in bits 17:16 of the add word
            wr(vif_pkg::REG_PORT_ADD, {14'h0, p[1:0], 4'h0, 12'h001});
            wr(vif_pkg::REG_PORT_ADD, {14'h0, p[1:0], 4'h0, 12'h005});
        end
        wr(vif_pkg::REG_PORT_ADD, 32'h0003_0002);
        wr(vif_pkg::REG_PORT_DEL, 32'h0000_0005);
        wr(vif_pkg::REG_TBL_ADDR, 32'h5);
        rd(vif_pkg::REG_TBL_DATA, 32'h16, "vid5 entry");
        // whole-entry write on a vid no frame below uses
        wr(vif_pkg::REG_TBL_ADDR, 32'ha);
        wr(vif_pkg::REG_TBL_DATA, 32'h1b);
        rd(vif_pkg::REG_TBL_ADDR, 32'ha, "tbl addr");
        rd(vif_pkg::REG_TBL_DATA, 32'h1b, "vid10 entry");
        push(2'h0, 1'b0, 12'h0, 4'hf);
        push(2'h3, 1'b0, 12'h0, 4'hf);
        push(2'h1, 1'b1, 12'h1, 4'hf);
        push(2'h3, 1'b1, 12'h5, 4'hf);
        push(2'h0, 1'b1, 12'h5, 4'h4);
        push(2'h0, 1'b1, 12'h9, 4'hf);
        push(2'h1, 1'b1, 12'h9, 4'hf);
        pop(1'b0, 4'h7, 12'h1, 8'h08);
        pop(1'b0, 4'h8, 12'h2, 8'h00);
        pop(1'b0, 4'h7, 12'h1, 8'h01);
        pop(1'b1, 4'h0, 12'h5, 8'h00);
        pop(1'b0, 4'h4, 12'h5, 8'h00);
        pop(1'b0, 4'h5, 12'h9, 8'h00);
        pop(1'b1, 4'h0, 12'h9, 8'h00);
        // consumer stalls: two entries fill the buffer and in_ready drops low
        @(posedge sys_clk);
        stall <= 1'b1;
        push(2'h2, 1'b0, 12'h0, 4'h1);
        push(2'h2, 1'b1, 12'h2, 4'hf);
        @(negedge sys_clk);
        chk("in_ready when full", 32'h0, {31'h0, in_ready});
        // head decision stands while stalled: untagged frame on vid 1
        chk("tag word", 32'h8100_0001, out_tag_word);
        chk("out_tagged", 32'h0, {31'h0, out_tagged});
        repeat (3) @(posedge sys_clk);
        stall <= 1'b0;
        pop(1'b0, 4'h1, 12'h1, 8'h00);
        pop(1'b0, 4'h8, 12'h2, 8'h00);
        rd(vif_pkg::REG_COUNTS, 32'h0002_0007, "counts");
        results();
    end
endmodule : vif_filter_tb
